// >>> shared/tws_if.sv
// Open-drain two-wire bus joining the slave end and the master end
interface tws_if;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic mst_scl_o;
  logic mst_scl_oe;
  logic mst_sda_o;
  logic mst_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND: a line is low if any enabled driver pulls it low
  assign scl = !(!mst_scl_oe && !mst_scl_o);
  assign sda = !((!mst_sda_oe && !mst_sda_o) || (!dev_sda_oe && !dev_sda_o));

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport mst (input scl, input sda, output mst_scl_o, output mst_scl_oe,
               output mst_sda_o, output mst_sda_oe);
endinterface : tws_if

// >>> shared/tws_pkg.sv
// Shared constants, types and decode helpers for the two-wire slave and master
package tws_pkg;

  // ----------------------------------------------------------------
  // Addresses and command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_PIN_LOW  = 7'h48;
  localparam logic [6:0] ADDR_PIN_HIGH = 7'h49;
  localparam logic [6:0] GC_ADDR       = 7'h00;
  localparam logic [7:0] GC_CMD_LATCH  = 8'h04;
  localparam logic [7:0] GC_CMD_RESET  = 8'h06;
  localparam logic [4:0] HS_CODE_TOP   = 5'h01;

  // ----------------------------------------------------------------
  // Bit positions and counts
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_ACK       = 4'h8;
  localparam logic [3:0] BIT_ACK_DONE  = 4'h9;
  localparam logic [2:0] LINE_SYNC_RST = 3'h7;
  localparam logic [1:0] ADDR_BOOT_RST = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ      = 64'd40000000;
  localparam longint unsigned TIMEOUT_MS  = 64'd54;
  localparam longint unsigned TIMEOUT_CYC = TIMEOUT_MS * CLK_HZ / 64'd1000;
  localparam longint unsigned SCL_HZ      = 64'd400000;
  localparam longint unsigned QUARTER_CYC = CLK_HZ / (64'd4 * SCL_HZ);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DS_IDLE   = 3'b000,
    DS_FIRST  = 3'b001,
    DS_GCCMD  = 3'b010,
    DS_RX     = 3'b011,
    DS_TX     = 3'b100,
    DS_IGNORE = 3'b101
  } tws_dev_state_e;

  typedef enum logic [1:0] {
    CMD_START = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_READ  = 2'b10,
    CMD_STOP  = 2'b11
  } tws_cmd_e;

  typedef enum logic [1:0] {
    MS_IDLE  = 2'b00,
    MS_START = 2'b01,
    MS_BIT   = 2'b10,
    MS_STOP  = 2'b11
  } tws_mst_state_e;

  function automatic logic tws_is_hs_code(input logic [7:0] b);
    return b[7:3] == HS_CODE_TOP;
  endfunction : tws_is_hs_code

endpackage : tws_pkg

// >>> test/twowire_slave_gencall_hs_timeout_tb.sv
// Bench joining the slave end and the master end over one two-wire link
module twowire_slave_gencall_hs_timeout_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam longint unsigned TOUT = 64'd2000;
  localparam logic [1:0]      CS   = tws_pkg::CMD_START;
  localparam logic [1:0]      CW   = tws_pkg::CMD_WRITE;
  localparam logic [1:0]      CR   = tws_pkg::CMD_READ;
  localparam logic [1:0]      CP   = tws_pkg::CMD_STOP;

  logic       clk, rst, pin, cmd_valid, nack_last, cmd_ready, done, ack_seen, last_first;
  logic       latched, hs_mode, regs_reset, timeout, tx_req, rx_valid, rx_first, busy;
  logic [1:0] cmd;
  logic [7:0] wdata, tx_data, rdata, rx_data, last_rx;
  int         n_fail = 0, n_checks = 0, n_rst = 0, n_tout = 0, n_tx = 0;

  tws_if bus ();

  tws_slave #(.TIMEOUT_CYCLES(TOUT)) i_tws_slave (
    .bus(bus), .i_clk(clk), .i_rst(rst), .i_address_select_pin(pin), .i_tx_data(tx_data),
    .o_addr_sel_latched(latched), .o_hs_mode(hs_mode), .o_regs_reset(regs_reset),
    .o_timeout(timeout), .o_tx_req(tx_req), .o_rx_valid(rx_valid), .o_rx_first(rx_first),
    .o_rx_data(rx_data), .o_busy(busy));

  tws_master #(.QUARTER(10)) i_tws_master (
    .bus(bus), .i_clk(clk), .i_rst(rst), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_wdata(wdata),
    .i_nack_last(nack_last), .o_cmd_ready(cmd_ready), .o_done(done), .o_rdata(rdata),
    .o_ack_seen(ack_seen));

  tws_link_sva #(.TIMEOUT_CYCLES(TOUT)) i_tws_link_sva (
    .i_clk(clk), .i_rst(rst), .scl(bus.scl), .sda(bus.sda), .dev_sda_oe(bus.dev_sda_oe),
    .o_busy(busy), .o_hs_mode(hs_mode), .o_timeout(timeout));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Pulses are caught mid-cycle, where registered outputs have settled
  always @(negedge clk) begin
    if (rx_valid === 1'b1) begin
      last_rx = rx_data;
      last_first = rx_first;
    end
    if (regs_reset === 1'b1) n_rst++;
    if (timeout === 1'b1) n_tout++;
    if (tx_req === 1'b1) n_tx++;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic send(input logic [1:0] c, input logic [7:0] d, input logic nk);
    int n;
    n = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1) @(negedge clk);
    cmd = c;
    wdata = d;
    nack_last = nk;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk("command done", 8'h01, {7'h00, done});
  endtask : send

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_write();
    pin = 1'b0;
    send(CS, 8'h00, 1'b0);
    chk("busy after start", 8'h01, busy);
    send(CW, 8'h90, 1'b0);
    chk("address ack", 8'h01, ack_seen);
    send(CW, 8'hA5, 1'b0);
    chk("data ack", 8'h01, ack_seen);
    chk("rx byte", 8'hA5, last_rx);
    chk("rx first", 8'h01, last_first);
    send(CW, 8'h3C, 1'b0);
    chk("rx second", 8'h3C, last_rx);
    chk("rx not first", 8'h00, last_first);
    send(CP, 8'h00, 1'b0);
    chk("busy after stop", 8'h00, busy);
    chk("idle lines", 8'h03, {6'h00, bus.scl, bus.sda});
  endtask : t_write

  task automatic t_wrong_addr();
    send(CS, 8'h00, 1'b0);
    send(CW, 8'h92, 1'b0);
    chk("other address ack", 8'h00, ack_seen);
    send(CW, 8'h11, 1'b0);
    chk("ignored byte ack", 8'h00, ack_seen);
    send(CP, 8'h00, 1'b0);
  endtask : t_wrong_addr

  task automatic t_read();
    pin = 1'b1;
    tx_data = 8'hB4;
    send(CS, 8'h00, 1'b0);
    send(CW, 8'h93, 1'b0);
    chk("read address ack", 8'h01, ack_seen);
    send(CR, 8'h00, 1'b0);
    chk("read byte", 8'hB4, rdata);
    send(CR, 8'h00, 1'b1);
    chk("last read byte", 8'hB4, rdata);
    send(CP, 8'h00, 1'b0);
    chk("lines after nack", 8'h03, {6'h00, bus.scl, bus.sda});
    chk("bytes taken", 8'h02, 8'(n_tx));
  endtask : t_read

  task automatic t_gencall();
    send(CS, 8'h00, 1'b0);
    pin = 1'b0;
    send(CW, 8'h00, 1'b0);
    chk("general call ack", 8'h01, ack_seen);
    send(CW, 8'h04, 1'b0);
    chk("latch command ack", 8'h01, ack_seen);
    send(CP, 8'h00, 1'b0);
    chk("pin relatched", 8'h00, latched);
    chk("no register reset", 8'h00, 8'(n_rst));
    send(CS, 8'h00, 1'b0);
    pin = 1'b1;
    send(CW, 8'h00, 1'b0);
    send(CW, 8'h06, 1'b0);
    send(CP, 8'h00, 1'b0);
    chk("pin relatched", 8'h01, latched);
    chk("register reset", 8'h01, 8'(n_rst));
    send(CS, 8'h00, 1'b0);
    send(CW, 8'h01, 1'b0);
    chk("general call read ack", 8'h00, ack_seen);
    send(CP, 8'h00, 1'b0);
  endtask : t_gencall

  task automatic t_hs();
    pin = 1'b0;
    send(CS, 8'h00, 1'b0);
    send(CW, 8'h0B, 1'b0);
    chk("hs code ack", 8'h00, ack_seen);
    chk("hs mode on", 8'h01, hs_mode);
    send(CS, 8'h00, 1'b0);
    chk("hs after restart", 8'h01, hs_mode);
    send(CW, 8'h90, 1'b0);
    chk("hs address ack", 8'h01, ack_seen);
    send(CW, 8'h77, 1'b0);
    chk("hs rx byte", 8'h77, last_rx);
    send(CP, 8'h00, 1'b0);
    chk("hs off after stop", 8'h00, hs_mode);
  endtask : t_hs

  task automatic t_timeout();
    int n;
    n = 0;
    tx_data = 8'h34;
    send(CS, 8'h00, 1'b0);
    send(CW, 8'h91, 1'b0);
    // Master now parks with clock low while the slave holds bit 7 low
    while (n_tout == 0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk("timeout pulses", 8'h01, 8'(n_tout));
    chk("busy after timeout", 8'h00, busy);
    chk("data released", 8'h01, bus.sda);
    send(CP, 8'h00, 1'b0);
    send(CS, 8'h00, 1'b0);
    send(CW, 8'h90, 1'b0);
    chk("ack after timeout", 8'h01, ack_seen);
    send(CP, 8'h00, 1'b0);
  endtask : t_timeout

  initial begin
    rst = 1'b1;
    pin = 1'b0;
    cmd_valid = 1'b0;
    cmd = 2'h0;
    wdata = 8'h00;
    nack_last = 1'b0;
    tx_data = 8'h00;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    t_write();
    t_wrong_addr();
    t_read();
    t_gencall();
    t_hs();
    t_timeout();
    conclude();
  end

  initial begin
    #1000000;
    n_fail++;
    $display("wrong value watchdog expected 0 seen 1");
    conclude();
  end
endmodule : twowire_slave_gencall_hs_timeout_tb

// >>> test/tws_link_sva.sv
// Concurrent checks on the two-wire link between the slave end and the master end
module tws_link_sva #(
  parameter longint unsigned TIMEOUT_CYCLES = 64'd2000
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic o_busy,
  input wire logic o_hs_mode,
  input wire logic o_timeout
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ----------------------------------------------------------------
  // Quiet-time counter
  // ----------------------------------------------------------------
  // Counts from raw line edges, so it runs a few cycles ahead of the synced copy
  longint unsigned quiet_cnt;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      quiet_cnt <= 64'd0;
    end else if (!o_busy || $rose(scl) || $rose(sda)) begin
      quiet_cnt <= 64'd0;
    end else begin
      quiet_cnt <= quiet_cnt + 64'd1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_start_busy: assert property ($fell(sda) && scl |-> ##[1:6] o_busy)
    else $error("busy did not follow a start condition");
  a_stop_idle: assert property ($rose(sda) && scl |-> ##[1:6] !o_busy)
    else $error("busy did not drop after a stop condition");
  a_idle_released: assert property (!o_busy && !$past(o_busy) |-> dev_sda_oe)
    else $error("slave drives data line outside a frame");
  a_ack_steady: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("slave changed data line while clock high");
  a_hs_no_ack: assert property ($rose(o_hs_mode) |-> (o_busy && dev_sda_oe) [*8])
    else $error("high-speed code was acknowledged");
  a_hs_hold: assert property (o_busy && $past(o_busy) && $past(o_hs_mode) |-> o_hs_mode)
    else $error("high-speed mode left inside a frame");
  a_tout_release: assert property (o_timeout |=> dev_sda_oe && !o_busy)
    else $error("slave still active after timeout");
  a_tout_late: assert property (quiet_cnt <= TIMEOUT_CYCLES + 64'd8)
    else $error("stuck bus not timed out");
  a_tout_early: assert property (o_timeout |-> quiet_cnt + 64'd8 >= TIMEOUT_CYCLES)
    else $error("timeout fired too early");
endmodule : tws_link_sva

// >>> verilog/tws_line_sync.sv
// Line synchroniser with edge, START and STOP detection
module tws_line_sync (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda,
  output logic      o_scl_rise,
  output logic      o_scl_fall,
  output logic      o_sda_rise,
  output logic      o_start,
  output logic      o_stop
);
  logic [2:0] scl_sh_reg;
  logic [2:0] sda_sh_reg;

  // Stage 0 is the metastable flop; only stage 1 reads it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_sh_reg <= tws_pkg::LINE_SYNC_RST;
      sda_sh_reg <= tws_pkg::LINE_SYNC_RST;
    end else begin
      scl_sh_reg <= {scl_sh_reg[1:0], i_scl};
      sda_sh_reg <= {sda_sh_reg[1:0], i_sda};
    end
  end

  assign o_scl      = scl_sh_reg[1];
  assign o_sda      = sda_sh_reg[1];
  assign o_scl_rise = scl_sh_reg[1] & ~scl_sh_reg[2];
  assign o_scl_fall = ~scl_sh_reg[1] & scl_sh_reg[2];
  assign o_sda_rise = sda_sh_reg[1] & ~sda_sh_reg[2];
  assign o_start    = scl_sh_reg[1] & scl_sh_reg[2] & ~sda_sh_reg[1] & sda_sh_reg[2];
  assign o_stop     = scl_sh_reg[1] & scl_sh_reg[2] & sda_sh_reg[1] & ~sda_sh_reg[2];
endmodule : tws_line_sync

// >>> verilog/tws_master.sv
// Master end: generates SCL from a divider and runs START, byte and STOP commands
module tws_master #(
  parameter int unsigned QUARTER = int'(tws_pkg::QUARTER_CYC)
) (
  tws_if.mst                bus,
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_cmd_valid,
  input  wire logic [1:0]   i_cmd,
  input  wire logic [7:0]   i_wdata,
  input  wire logic         i_nack_last,
  output logic              o_cmd_ready,
  output logic              o_done,
  output logic [7:0]        o_rdata,
  output logic              o_ack_seen
);
  tws_pkg::tws_mst_state_e state_reg;
  logic [15:0] div_reg;
  logic        tick;
  logic [1:0]  q_reg;
  logic [3:0]  bit_reg;
  logic [7:0]  sh_reg;
  logic        is_read_reg;
  logic        nack_reg;
  logic        scl_low_reg;
  logic        sda_low_reg;
  logic        sda;

  tws_line_sync u_sync (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_scl      (bus.scl),
    .i_sda      (bus.sda),
    .o_scl      (),
    .o_sda      (sda),
    .o_scl_rise (),
    .o_scl_fall (),
    .o_sda_rise (),
    .o_start    (),
    .o_stop     ()
  );

  assign bus.mst_scl_o  = 1'b0;
  assign bus.mst_sda_o  = 1'b0;
  assign bus.mst_scl_oe = !scl_low_reg;
  assign bus.mst_sda_oe = !sda_low_reg;
  assign o_cmd_ready    = (state_reg == tws_pkg::MS_IDLE);

  // ----------------------------------------------------------------
  // Quarter-bit enable; QUARTER keeps SCL well above the 1 kHz floor
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_reg <= 16'h0;
    end else if (state_reg == tws_pkg::MS_IDLE || tick) begin
      div_reg <= 16'h0;
    end else begin
      div_reg <= div_reg + 16'h1;
    end
  end

  assign tick = (state_reg != tws_pkg::MS_IDLE) && (div_reg == 16'(QUARTER - 1));

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg   <= tws_pkg::MS_IDLE;
      q_reg       <= 2'h0;
      bit_reg     <= 4'h0;
      sh_reg      <= 8'h0;
      is_read_reg <= 1'b0;
      nack_reg    <= 1'b0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      o_done      <= 1'b0;
      o_rdata     <= 8'h0;
      o_ack_seen  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (state_reg == tws_pkg::MS_IDLE) begin
        if (i_cmd_valid) begin
          q_reg       <= 2'h0;
          bit_reg     <= 4'h0;
          sh_reg      <= i_wdata;
          is_read_reg <= (i_cmd == tws_pkg::CMD_READ);
          nack_reg    <= i_nack_last;
          case (i_cmd)
            tws_pkg::CMD_START: state_reg <= tws_pkg::MS_START;
            tws_pkg::CMD_STOP:  state_reg <= tws_pkg::MS_STOP;
            default:            state_reg <= tws_pkg::MS_BIT;
          endcase
        end
      end else if (tick) begin
        q_reg <= q_reg + 2'h1;
        case (state_reg)
          tws_pkg::MS_START: begin
            case (q_reg)
              2'h0:    sda_low_reg <= 1'b0;
              2'h1:    scl_low_reg <= 1'b0;
              2'h2:    sda_low_reg <= 1'b1;
              default: scl_low_reg <= 1'b1;
            endcase
          end
          tws_pkg::MS_STOP: begin
            case (q_reg)
              2'h0:    sda_low_reg <= 1'b1;
              2'h1:    scl_low_reg <= 1'b0;
              2'h2:    sda_low_reg <= 1'b0;
              default: begin
              end
            endcase
          end
          default: begin
            case (q_reg)
              2'h0: begin
                if (bit_reg == tws_pkg::BIT_ACK) begin
                  sda_low_reg <= is_read_reg && !nack_reg;
                end else begin
                  sda_low_reg <= !is_read_reg && !sh_reg[7];
                end
              end
              2'h1: scl_low_reg <= 1'b0;
              2'h2: begin
                if (bit_reg == tws_pkg::BIT_ACK) begin
                  o_ack_seen <= !sda;
                end else if (is_read_reg) begin
                  sh_reg <= {sh_reg[6:0], sda};
                end
              end
              default: begin
                scl_low_reg <= 1'b1;
                bit_reg     <= bit_reg + 4'h1;
                if (!is_read_reg) begin
                  sh_reg <= {sh_reg[6:0], 1'b0};
                end
              end
            endcase
          end
        endcase
        if (q_reg == 2'h3 && (state_reg != tws_pkg::MS_BIT || bit_reg == tws_pkg::BIT_ACK)) begin
          state_reg <= tws_pkg::MS_IDLE;
          o_done    <= 1'b1;
          if (is_read_reg) begin
            o_rdata <= sh_reg;
          end
        end
      end
    end
  end
endmodule : tws_master

// >>> verilog/tws_slave.sv
// Slave end: addressing, general call, high-speed mode and bus-stuck timeout
// How it works
// - Ack general call write, next byte is command
// - Command 04h relatches address pin only
// - Command 06h relatches pin, resets registers
// - Master sends high-speed code first after START
// - Never ack high-speed code, enter high-speed mode
// - Master follows code with a slave address
// - High-speed mode lasts until STOP
// - Line low 54 ms in frame resets interface
// - After timeout, release SDA and await START
// - Master keeps SCL at least 1 kHz
// - SDA fall with SCL high is START
// - SDA rise with SCL high is STOP
// - Both lines high outside frame is idle
// - Byte count per frame is unlimited
// - Receiver acks by holding SDA low
// - Master nack ends a read
// - Address 48h or 49h from latched pin
// - MSB first; device is slave only
module tws_slave #(
  parameter longint unsigned TIMEOUT_CYCLES = tws_pkg::TIMEOUT_CYC
) (
  tws_if.dev                bus,
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_address_select_pin,
  input  wire logic [7:0]   i_tx_data,
  output logic              o_addr_sel_latched,
  output logic              o_hs_mode,
  output logic              o_regs_reset,
  output logic              o_timeout,
  output logic              o_tx_req,
  output logic              o_rx_valid,
  output logic              o_rx_first,
  output logic [7:0]        o_rx_data,
  output logic              o_busy
);
  localparam logic [31:0] TO_LIM = 32'(TIMEOUT_CYCLES - 64'd1);

  tws_pkg::tws_dev_state_e state_reg;
  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic       sda_rise;
  logic       start_det;
  logic       stop_det;
  logic [1:0] pin_sync_reg;
  logic [1:0] boot_cnt_reg;
  logic       relatch_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_sh_reg;
  logic       mack_reg;
  logic       sda_low_reg;
  logic       first_pend_reg;
  logic       in_frame_reg;
  logic [31:0] to_cnt_reg;
  logic       timeout_hit;
  logic [6:0] own_addr;
  logic       byte_end;

  tws_line_sync u_sync (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_scl      (bus.scl),
    .i_sda      (bus.sda),
    .o_scl      (scl),
    .o_sda      (sda),
    .o_scl_rise (scl_rise),
    .o_scl_fall (scl_fall),
    .o_sda_rise (sda_rise),
    .o_start    (start_det),
    .o_stop     (stop_det)
  );

  // ----------------------------------------------------------------
  // Open-drain SDA, never SCL: slave only
  // ----------------------------------------------------------------
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = !sda_low_reg;
  assign o_busy         = in_frame_reg;
  assign own_addr = o_addr_sel_latched ? tws_pkg::ADDR_PIN_HIGH : tws_pkg::ADDR_PIN_LOW;
  assign byte_end = scl_fall && (bit_cnt_reg == tws_pkg::BIT_ACK);

  // ----------------------------------------------------------------
  // Address pin capture
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_sync_reg <= 2'h0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], i_address_select_pin};
    end
  end

  // Latched after reset, at START and on general call commands 04h and 06h, to save sensing power
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      boot_cnt_reg       <= tws_pkg::ADDR_BOOT_RST;
      o_addr_sel_latched <= 1'b0;
    end else begin
      if (boot_cnt_reg != 2'h0) begin
        boot_cnt_reg <= boot_cnt_reg - 2'h1;
      end
      if (boot_cnt_reg != 2'h0 || relatch_reg) begin
        o_addr_sel_latched <= pin_sync_reg[1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame tracking and bus-stuck timeout
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      in_frame_reg <= 1'b0;
    end else if (start_det) begin
      in_frame_reg <= 1'b1;
    end else if (stop_det || timeout_hit) begin
      in_frame_reg <= 1'b0;
    end
  end

  // Any rising edge restarts the count; both lines high is not stuck
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      to_cnt_reg <= 32'h0;
    end else if (!in_frame_reg || scl_rise || sda_rise || (scl && sda)) begin
      to_cnt_reg <= 32'h0;
    end else if (to_cnt_reg != TO_LIM) begin
      to_cnt_reg <= to_cnt_reg + 32'h1;
    end
  end

  assign timeout_hit = in_frame_reg && (to_cnt_reg == TO_LIM);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_timeout <= 1'b0;
    end else begin
      o_timeout <= timeout_hit;
    end
  end

  // ----------------------------------------------------------------
  // High-speed filter select
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hs_mode <= 1'b0;
    end else if (stop_det || timeout_hit) begin
      o_hs_mode <= 1'b0;
    end else if (byte_end && state_reg == tws_pkg::DS_FIRST && tws_pkg::tws_is_hs_code(shift_reg)) begin
      o_hs_mode <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Protocol engine: sample on SCL rise, drive on SCL fall
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg      <= tws_pkg::DS_IDLE;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h0;
      tx_sh_reg      <= 8'h0;
      mack_reg       <= 1'b1;
      sda_low_reg    <= 1'b0;
      first_pend_reg <= 1'b0;
      relatch_reg    <= 1'b0;
      o_regs_reset   <= 1'b0;
      o_rx_valid     <= 1'b0;
      o_rx_first     <= 1'b0;
      o_rx_data      <= 8'h0;
      o_tx_req       <= 1'b0;
    end else begin
      relatch_reg  <= 1'b0;
      o_regs_reset <= 1'b0;
      o_rx_valid   <= 1'b0;
      o_tx_req     <= 1'b0;
      if (timeout_hit) begin
        state_reg   <= tws_pkg::DS_IDLE;
        sda_low_reg <= 1'b0;
      end else if (start_det) begin
        state_reg   <= tws_pkg::DS_FIRST;
        bit_cnt_reg <= 4'h0;
        sda_low_reg <= 1'b0;
        relatch_reg <= 1'b1;
      end else if (stop_det) begin
        state_reg   <= tws_pkg::DS_IDLE;
        sda_low_reg <= 1'b0;
      end else if (state_reg != tws_pkg::DS_IDLE) begin
        if (scl_rise) begin
          if (bit_cnt_reg < tws_pkg::BIT_ACK) begin
            shift_reg <= {shift_reg[6:0], sda};
          end else begin
            mack_reg <= sda;
          end
          if (bit_cnt_reg != tws_pkg::BIT_ACK_DONE) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end else if (byte_end) begin
          sda_low_reg <= 1'b0;
          case (state_reg)
            tws_pkg::DS_FIRST: begin
              if (tws_pkg::tws_is_hs_code(shift_reg)) begin
                state_reg <= tws_pkg::DS_IGNORE;
              end else if (shift_reg == {tws_pkg::GC_ADDR, 1'b0}) begin
                sda_low_reg <= 1'b1;
                state_reg   <= tws_pkg::DS_GCCMD;
              end else if (shift_reg[7:1] == own_addr) begin
                sda_low_reg    <= 1'b1;
                first_pend_reg <= 1'b1;
                state_reg      <= shift_reg[0] ? tws_pkg::DS_TX : tws_pkg::DS_RX;
              end else begin
                state_reg <= tws_pkg::DS_IGNORE;
              end
            end
            tws_pkg::DS_GCCMD: begin
              sda_low_reg <= 1'b1;
              state_reg   <= tws_pkg::DS_IGNORE;
              if (shift_reg == tws_pkg::GC_CMD_LATCH) begin
                relatch_reg <= 1'b1;
              end else if (shift_reg == tws_pkg::GC_CMD_RESET) begin
                relatch_reg  <= 1'b1;
                o_regs_reset <= 1'b1;
              end
            end
            tws_pkg::DS_RX: begin
              sda_low_reg    <= 1'b1;
              o_rx_data      <= shift_reg;
              o_rx_valid     <= 1'b1;
              o_rx_first     <= first_pend_reg;
              first_pend_reg <= 1'b0;
            end
            default: begin
            end
          endcase
        end else if (scl_fall && bit_cnt_reg == tws_pkg::BIT_ACK_DONE) begin
          bit_cnt_reg <= 4'h0;
          // Own address ack reads back low, so the first byte loads too
          if (state_reg == tws_pkg::DS_TX && !mack_reg) begin
            tx_sh_reg   <= i_tx_data;
            o_tx_req    <= 1'b1;
            sda_low_reg <= !i_tx_data[7];
          end else begin
            sda_low_reg <= 1'b0;
            if (state_reg == tws_pkg::DS_TX) begin
              state_reg <= tws_pkg::DS_IGNORE;
            end
          end
        end else if (scl_fall && state_reg == tws_pkg::DS_TX && bit_cnt_reg != 4'h0) begin
          tx_sh_reg   <= {tx_sh_reg[6:0], 1'b0};
          sda_low_reg <= !tx_sh_reg[6];
        end
      end
    end
  end
endmodule : tws_slave
